// ===== shared/tx_ls_pkg.sv
package tx_ls_pkg;
  // ---------------------------------------------
  // Ring geometry
  // ---------------------------------------------
  localparam int RING_DEPTH = 1024;
  localparam int IDX_W = $clog2(RING_DEPTH);
  // ---------------------------------------------
  // Command double word 0 layout
  // ---------------------------------------------
  localparam int OWN_BIT = 31;
  localparam int RING_END_BIT = 30;
  localparam int FIRST_BIT = 29;
  localparam int LAST_BIT = 28;
  localparam int BIG_SEND_BIT = 27;
  localparam int MSS_MSB = 26;
  localparam int MSS_LSB = 16;
  localparam int LEN_MSB = 15;
  localparam int LEN_LSB = 0;
  localparam logic [31:0] OWN_MASK = 32'h8000_0000;
  // ---------------------------------------------
  // Command double word 1 layout
  // ---------------------------------------------
  localparam int VLAN_INS_BIT = 17;
  localparam int TAG_MSB = 15;
  localparam int TAG_LSB = 0;
  localparam int VID_LOW_MSB = 15;
  localparam int VID_LOW_LSB = 8;
  localparam int RANK_MSB = 7;
  localparam int RANK_LSB = 5;
  localparam int CFI_BIT = 4;
  localparam int VID_HIGH_MSB = 3;
  localparam int VID_HIGH_LSB = 0;
  // ---------------------------------------------
  // Framing constants
  // ---------------------------------------------
  localparam logic [15:0] TPID = 16'h8100;
  localparam logic [3:0] HDR_BYTES = 4'hc;
  localparam logic [1:0] TAG_LAST = 2'h3;
  localparam logic [15:0] LEN_ONE = 16'h0001;
  localparam logic [16:0] MAX_FRAME = 17'h0_ffff;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_W = 9;
endpackage

// ===== rtl/tx_desc_fields.sv
`timescale 1ns/1ps
`default_nettype none
module tx_desc_fields
  import tx_ls_pkg::*;
(
  // Raw descriptor
  input wire logic [31:0] dw0,
  input wire logic [31:0] dw1,
  input wire logic [31:0] dw2,
  input wire logic [31:0] dw3,
  // Decoded fields
  output logic own,
  output logic ring_end,
  output logic first,
  output logic last,
  output logic big_send,
  output logic [10:0] segment_size_limit,
  output logic [15:0] len,
  output logic vlan_ins,
  output logic [15:0] vlan_info,
  output logic [63:0] addr
);
  // ---------------------------------------------
  // Field split, reserved bits unused
  // ---------------------------------------------
  assign own = dw0[OWN_BIT];
  assign ring_end = dw0[RING_END_BIT];
  assign first = dw0[FIRST_BIT];
  assign last = dw0[LAST_BIT];
  assign big_send = dw0[BIG_SEND_BIT];
  // Size field only meaningful in large-send format
  assign segment_size_limit = big_send ? dw0[MSS_MSB:MSS_LSB] : 11'h000;
  assign len = dw0[LEN_MSB:LEN_LSB];
  assign vlan_ins = dw1[VLAN_INS_BIT];
  assign vlan_info = dw1[TAG_MSB:TAG_LSB];
  assign addr = {dw3, dw2};
endmodule
`default_nettype wire

// ===== rtl/tx_byte_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module tx_byte_fifo
  import tx_ls_pkg::*;
#(
  parameter int W = FIFO_W,
  parameter int D = FIFO_DEPTH
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready,
  output logic empty
);
  localparam int AW = $clog2(D);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } fifo_s;

  fifo_s q_ff;
  fifo_s nxt_q;
  logic wr;
  logic rd;

  assign in_ready = q_ff.cnt != FULL_CNT;
  assign out_valid = q_ff.cnt != '0;
  assign empty = !out_valid;
  assign out_data = q_ff.mem[q_ff.rp];
  assign wr = in_valid && in_ready;
  assign rd = out_valid && out_ready;

  // ---------------------------------------------
  // Pointer and count update
  // ---------------------------------------------
  always_comb
  begin
    nxt_q = q_ff;
    if (wr)
    begin
      nxt_q.mem[q_ff.wp] = in_data;
      nxt_q.wp = q_ff.wp + 1'b1;
    end
    if (rd)
      nxt_q.rp = q_ff.rp + 1'b1;
    if (wr && !rd)
      nxt_q.cnt = q_ff.cnt + 1'b1;
    else if (rd && !wr)
      nxt_q.cnt = q_ff.cnt - 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      q_ff <= '0;
    else
      q_ff <= nxt_q;
  end
endmodule
`default_nettype wire

// ===== rtl/tx_large_send_descriptor_parser.sv
// What this block does
// - Owned descriptor means buffer ready to send
// - Clear ownership once descriptor data sent
// - Ring end flag wraps pointer to zero
// - First segment flag opens packet assembly
// - Last segment flag closes packet assembly
// - Large-send flag selects large-send command format
// - Eleven-bit segment size drives segmentation
// - Byte count is buffer bytes to send
// - Tag insert puts 0x8100 after source address
// - Tag info bytes follow inserted protocol id
// - Without tag insert frame passes unchanged
// - Tag info holds id, priority, format bit
// - Buffer address joins low and high words
// - Ring holds up to 1024 four-word descriptors
`timescale 1ns/1ps
`default_nettype none
module tx_large_send_descriptor_parser
  import tx_ls_pkg::*;
(
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // Control and status
  input wire logic TX_ENABLE,
  input wire logic TX_KICK,
  input wire logic ERR_CLEAR,
  output logic ENGINE_BUSY,
  output logic PKT_SENT,
  output logic ERR_OVERSIZE,
  output logic ERR_SEQUENCE,
  // Descriptor fetch
  output logic DESC_REQ,
  output logic [IDX_W-1:0] DESC_IDX,
  input wire logic DESC_VALID,
  input wire logic [31:0] DESC_DW0,
  input wire logic [31:0] DESC_DW1,
  input wire logic [31:0] DESC_DW2,
  input wire logic [31:0] DESC_DW3,
  // Descriptor return
  output logic DESC_WB_VALID,
  output logic [IDX_W-1:0] DESC_WB_IDX,
  output logic [31:0] DESC_WB_DW0,
  // Buffer read
  output logic BUF_REQ,
  output logic [63:0] BUF_ADDR,
  output logic [15:0] BUF_LEN,
  input wire logic [7:0] IN_DATA,
  input wire logic IN_VALID,
  output logic IN_READY,
  // Frame out
  output logic [7:0] TX_DATA,
  output logic TX_LAST,
  output logic TX_VALID,
  input wire logic TX_READY,
  // Current packet tag
  output logic LARGE_SEND,
  output logic [11:0] VLAN_ID,
  output logic [2:0] VLAN_RANK,
  output logic VLAN_CFI
);
  typedef enum logic [2:0] {S_IDLE, S_FETCH, S_STREAM, S_DRAIN, S_WB} st_e;

  typedef struct packed {
    st_e st;
    logic pend;
    logic [IDX_W-1:0] idx;
    logic [31:0] dw0;
    logic [15:0] rem;
    logic [3:0] hdr;
    logic [1:0] ins;
    logic ins_done;
    logic vlan;
    logic [15:0] tag;
    logic lgs;
    logic [10:0] segment_size_limit;
    logic [10:0] seg;
    logic last_desc;
    logic ring_end;
    logic in_pkt;
    logic [16:0] pkt_bytes;
    logic [63:0] addr;
    logic buf_req;
    logic err_big;
    logic err_seq;
  } state_s;

  state_s cur_ff;
  state_s nxt_cur;

  logic f_own;
  logic f_ring_end;
  logic f_first;
  logic f_last;
  logic f_big;
  logic [10:0] f_mss;
  logic [15:0] f_len;
  logic f_vlan_ins;
  logic [15:0] f_vlan_info;
  logic [63:0] f_addr;
  logic fifo_rdy;
  logic fifo_empty;
  logic push;
  logic [7:0] push_byte;
  logic push_last;
  logic inserting;
  logic seg_end;
  logic set_big;
  logic set_seq;

  // ---------------------------------------------
  // Tag byte order on the wire
  // ---------------------------------------------
  function automatic logic [7:0] tag_byte(input logic [1:0] n,
                                          input logic [15:0] tag);
    logic [7:0] b;
    case (n)
      2'h0: b = TPID[15:8];
      2'h1: b = TPID[7:0];
      2'h2: b = tag[7:0];
      default: b = tag[15:8];
    endcase
    return b;
  endfunction

  // ---------------------------------------------
  // Submodules
  // ---------------------------------------------
  tx_desc_fields u_fields (
    .dw0(DESC_DW0),
    .dw1(DESC_DW1),
    .dw2(DESC_DW2),
    .dw3(DESC_DW3),
    .own(f_own),
    .ring_end(f_ring_end),
    .first(f_first),
    .last(f_last),
    .big_send(f_big),
    .segment_size_limit(f_mss),
    .len(f_len),
    .vlan_ins(f_vlan_ins),
    .vlan_info(f_vlan_info),
    .addr(f_addr)
  );

  tx_byte_fifo #(
    .W(FIFO_W),
    .D(FIFO_DEPTH)
  ) u_fifo (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .in_valid(push),
    .in_data({push_last, push_byte}),
    .in_ready(fifo_rdy),
    .out_valid(TX_VALID),
    .out_data({TX_LAST, TX_DATA}),
    .out_ready(TX_READY),
    .empty(fifo_empty)
  );

  // ---------------------------------------------
  // Port view of state
  // ---------------------------------------------
  assign inserting = cur_ff.vlan && cur_ff.hdr == HDR_BYTES &&
                     !cur_ff.ins_done;
  assign seg_end = cur_ff.lgs && cur_ff.segment_size_limit != '0 &&
                   cur_ff.seg == cur_ff.segment_size_limit - 11'h001;
  assign IN_READY = cur_ff.st == S_STREAM && !inserting && fifo_rdy;
  assign ENGINE_BUSY = cur_ff.st != S_IDLE;
  assign DESC_REQ = cur_ff.st == S_FETCH;
  assign DESC_IDX = cur_ff.idx;
  assign DESC_WB_VALID = cur_ff.st == S_WB;
  assign DESC_WB_IDX = cur_ff.idx;
  assign DESC_WB_DW0 = cur_ff.dw0 & ~OWN_MASK;
  assign PKT_SENT = cur_ff.st == S_WB && cur_ff.last_desc;
  assign BUF_REQ = cur_ff.buf_req;
  assign BUF_ADDR = cur_ff.addr;
  assign BUF_LEN = cur_ff.rem;
  assign ERR_OVERSIZE = cur_ff.err_big;
  assign ERR_SEQUENCE = cur_ff.err_seq;
  assign LARGE_SEND = cur_ff.lgs;
  assign VLAN_ID = {cur_ff.tag[VID_HIGH_MSB:VID_HIGH_LSB],
                    cur_ff.tag[VID_LOW_MSB:VID_LOW_LSB]};
  assign VLAN_RANK = cur_ff.tag[RANK_MSB:RANK_LSB];
  assign VLAN_CFI = cur_ff.tag[CFI_BIT];

  // ---------------------------------------------
  // Engine next state
  // ---------------------------------------------
  always_comb
  begin
    nxt_cur = cur_ff;
    nxt_cur.buf_req = 1'b0;
    push = 1'b0;
    push_byte = 8'h00;
    push_last = 1'b0;
    set_big = 1'b0;
    set_seq = 1'b0;
    case (cur_ff.st)
      S_IDLE:
      begin
        if (TX_ENABLE && (cur_ff.pend || TX_KICK))
        begin
          nxt_cur.pend = 1'b0;
          nxt_cur.st = S_FETCH;
        end
      end
      S_FETCH:
      begin
        if (DESC_VALID)
        begin
          if (!f_own)
            nxt_cur.st = S_IDLE;
          else
          begin
            nxt_cur.dw0 = DESC_DW0;
            nxt_cur.rem = f_len;
            nxt_cur.addr = f_addr;
            nxt_cur.last_desc = f_last;
            nxt_cur.ring_end = f_ring_end;
            if (f_first)
            begin
              nxt_cur.in_pkt = 1'b1;
              nxt_cur.vlan = f_vlan_ins;
              nxt_cur.tag = f_vlan_info;
              nxt_cur.lgs = f_big;
              nxt_cur.segment_size_limit = f_mss;
              nxt_cur.hdr = '0;
              nxt_cur.ins = '0;
              nxt_cur.ins_done = 1'b0;
              nxt_cur.seg = '0;
              nxt_cur.pkt_bytes = '0;
            end
            else if (!cur_ff.in_pkt)
              set_seq = 1'b1;
            if (f_len == '0)
              nxt_cur.st = S_DRAIN;
            else
            begin
              nxt_cur.buf_req = 1'b1;
              nxt_cur.st = S_STREAM;
            end
          end
        end
      end
      S_STREAM:
      begin
        if (inserting)
        begin
          if (fifo_rdy)
          begin
            push = 1'b1;
            push_byte = tag_byte(cur_ff.ins, cur_ff.tag);
            nxt_cur.ins = cur_ff.ins + 1'b1;
            if (cur_ff.ins == TAG_LAST)
              nxt_cur.ins_done = 1'b1;
          end
        end
        else if (IN_VALID && fifo_rdy)
        begin
          push = 1'b1;
          push_byte = IN_DATA;
          push_last = seg_end ||
                      (cur_ff.rem == LEN_ONE && cur_ff.last_desc);
          nxt_cur.rem = cur_ff.rem - LEN_ONE;
          if (cur_ff.hdr != HDR_BYTES)
            nxt_cur.hdr = cur_ff.hdr + 1'b1;
          if (cur_ff.lgs && cur_ff.segment_size_limit != '0)
            nxt_cur.seg = seg_end ? '0 : cur_ff.seg + 1'b1;
          if (cur_ff.pkt_bytes == MAX_FRAME)
            set_big = 1'b1;
          else
            nxt_cur.pkt_bytes = cur_ff.pkt_bytes + 1'b1;
          if (cur_ff.rem == LEN_ONE)
            nxt_cur.st = S_DRAIN;
        end
      end
      S_DRAIN:
      begin
        if (fifo_empty)
          nxt_cur.st = S_WB;
      end
      S_WB:
      begin
        if (cur_ff.ring_end)
          nxt_cur.idx = '0;
        else
          nxt_cur.idx = cur_ff.idx + 1'b1;
        if (cur_ff.last_desc)
          nxt_cur.in_pkt = 1'b0;
        nxt_cur.st = TX_ENABLE ? S_FETCH : S_IDLE;
      end
      default:
        nxt_cur.st = S_IDLE;
    endcase
    if (ERR_CLEAR)
    begin
      nxt_cur.err_big = 1'b0;
      nxt_cur.err_seq = 1'b0;
    end
    if (set_big)
      nxt_cur.err_big = 1'b1;
    if (set_seq)
      nxt_cur.err_seq = 1'b1;
    if (TX_KICK && cur_ff.st != S_IDLE)
      nxt_cur.pend = 1'b1;
  end

  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
      cur_ff <= '0;
    else
      cur_ff <= nxt_cur;
  end

  // ---------------------------------------------
  // Checks
  // ---------------------------------------------
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_N);

  a_empty_ring_stop: assert property (
    cur_ff.st == S_FETCH && DESC_VALID && !f_own |=>
      cur_ff.st == S_IDLE && $stable(cur_ff.idx))
    else $error("unowned descriptor not parked");
  a_own_returned: assert property (
    DESC_WB_VALID |-> !DESC_WB_DW0[OWN_BIT] && !TX_VALID)
    else $error("ownership returned too early");
  a_ring_wrap: assert property (
    DESC_WB_VALID && cur_ff.ring_end |=> DESC_IDX == '0)
    else $error("ring end did not wrap");
  a_ring_step: assert property (
    DESC_WB_VALID && !cur_ff.ring_end |=>
      DESC_IDX == IDX_W'($past(cur_ff.idx) + 1'b1))
    else $error("ring pointer did not step");
  a_first_opens: assert property (
    cur_ff.st == S_FETCH && DESC_VALID && f_own && f_first |=>
      cur_ff.hdr == '0 && cur_ff.in_pkt &&
      cur_ff.vlan == $past(f_vlan_ins))
    else $error("first segment did not open packet");
  a_mss_loaded: assert property (
    cur_ff.st == S_FETCH && DESC_VALID && f_own && f_first |=>
      cur_ff.lgs == $past(f_big) &&
      cur_ff.segment_size_limit == ($past(f_big) ? $past(DESC_DW0[MSS_MSB:MSS_LSB]) : '0))
    else $error("segment size not taken");
  a_len_to_buf: assert property (
    BUF_REQ |-> BUF_LEN == $past(f_len) &&
      BUF_ADDR == {$past(DESC_DW3), $past(DESC_DW2)})
    else $error("buffer request wrong");
  a_last_marks: assert property (
    push && !inserting && cur_ff.rem == LEN_ONE && cur_ff.last_desc
      |-> push_last ##1 cur_ff.st == S_DRAIN)
    else $error("packet end not marked");
  a_tpid_first: assert property (
    push && inserting && cur_ff.ins == '0 |->
      push_byte == TPID[15:8] && cur_ff.hdr == HDR_BYTES)
    else $error("protocol id misplaced");
  a_tag_bytes: assert property (
    push && inserting && cur_ff.ins == TAG_LAST |->
      push_byte == cur_ff.tag[15:8] ##1 cur_ff.ins_done)
    else $error("tag bytes wrong");
  a_plain_copy: assert property (
    push && !cur_ff.vlan |-> push_byte == IN_DATA && IN_READY)
    else $error("untagged frame altered");
  a_seg_bound: assert property (
    cur_ff.lgs && cur_ff.segment_size_limit != '0 |-> cur_ff.seg < cur_ff.segment_size_limit)
    else $error("segment overran size");

  c_ring_wrap: cover property (DESC_WB_VALID && cur_ff.ring_end);
  c_tag_done: cover property (push && inserting && cur_ff.ins == TAG_LAST);
  c_seg_split: cover property (push && seg_end && !cur_ff.last_desc);
  c_stall: cover property (cur_ff.st == S_STREAM && !fifo_rdy);
endmodule
`default_nettype wire

// ===== dv/host_ring_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_ring_model
  import tx_ls_pkg::*;
#(
  parameter int DLY = 2
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Descriptor fetch and return
  input wire logic desc_req,
  input wire logic [IDX_W-1:0] desc_idx,
  output logic desc_valid,
  output logic [31:0] dw0,
  output logic [31:0] dw1,
  output logic [31:0] dw2,
  output logic [31:0] dw3,
  input wire logic wb_valid,
  input wire logic [IDX_W-1:0] wb_idx,
  input wire logic [31:0] wb_dw0,
  // Buffer bytes
  input wire logic buf_req,
  input wire logic [63:0] buf_addr,
  input wire logic [15:0] buf_len,
  output logic [7:0] in_data,
  output logic in_valid,
  input wire logic in_ready,
  input wire logic stall
);
  // ---------------------------------------------
  // Descriptor ring in host memory
  // ---------------------------------------------
  // Indexed from an aligned ring base, sixteen bytes a slot
  logic [31:0] ring [RING_DEPTH][4];
  logic [7:0] base;
  logic [7:0] off;
  logic [15:0] left;
  int wcnt;
  // Words scrambled outside the valid cycle
  assign dw0 = desc_valid ? ring[desc_idx][0] : ~ring[desc_idx][0];
  assign dw1 = desc_valid ? ring[desc_idx][1] : ~ring[desc_idx][1];
  assign dw2 = desc_valid ? ring[desc_idx][2] : ~ring[desc_idx][2];
  assign dw3 = desc_valid ? ring[desc_idx][3] : ~ring[desc_idx][3];
  assign in_data = in_valid ? base + off : ~(base + off);
  // ---------------------------------------------
  // Fetch answer, return, byte source
  // ---------------------------------------------
  always @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      desc_valid <= 1'b0;
      wcnt <= 0;
      in_valid <= 1'b0;
      left <= 16'h0000;
      off <= 8'h00;
      base <= 8'h00;
    end
    else
    begin
      desc_valid <= desc_req && !desc_valid && wcnt >= DLY;
      wcnt <= (desc_req && !desc_valid) ? wcnt + 1 : 0;
      if (wb_valid)
        ring[wb_idx][0] <= wb_dw0;
      if (buf_req)
      begin
        base <= buf_addr[7:0];
        left <= buf_len;
        off <= 8'h00;
      end
      else if (in_valid && in_ready)
      begin
        off <= off + 8'h01;
        left <= left - 16'h0001;
        in_valid <= left > 16'h0001 && !stall;
      end
      else if (!in_valid && left != 16'h0000)
        in_valid <= !stall;
    end
endmodule
`default_nettype wire

// ===== dv/tx_large_send_descriptor_parser_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tx_large_send_descriptor_parser_tb
  import tx_ls_pkg::*;
;
  logic core_clk, rst_n, tx_enable, tx_kick, err_clear, in_stall, tx_ready;
  logic engine_busy, pkt_sent, err_oversize, err_sequence, desc_req;
  logic desc_valid, wb_valid, buf_req, in_valid, in_ready, tx_last;
  logic tx_valid, large_send, vlan_cfi, hold, ignore, cur_ins, cur_lg;
  logic [IDX_W-1:0] desc_idx, wb_idx;
  logic [31:0] dw0, dw1, dw2, dw3, wb_dw0, seed, r;
  logic [31:0] armed [4];
  logic [63:0] buf_addr;
  logic [15:0] buf_len, cur_tag;
  logic [7:0] in_data, tx_data;
  logic [11:0] vlan_id;
  logic [2:0] vlan_rank;
  logic [16:0] p;
  logic [8:0] exp_q [$];
  logic [79:0] buf_q [$];
  logic [16:0] pkt_q [$];
  int bad_count, tests_run, pkt_cnt, cur_mss;
  // ---------------------------------------------
  // Instances
  // ---------------------------------------------
  tx_large_send_descriptor_parser tx_large_send_descriptor_parser_i (
    .CORE_CLK(core_clk), .RST_N(rst_n), .TX_ENABLE(tx_enable),
    .TX_KICK(tx_kick), .ERR_CLEAR(err_clear), .ENGINE_BUSY(engine_busy),
    .PKT_SENT(pkt_sent), .ERR_OVERSIZE(err_oversize),
    .ERR_SEQUENCE(err_sequence), .DESC_REQ(desc_req), .DESC_IDX(desc_idx),
    .DESC_VALID(desc_valid), .DESC_DW0(dw0), .DESC_DW1(dw1),
    .DESC_DW2(dw2), .DESC_DW3(dw3), .DESC_WB_VALID(wb_valid),
    .DESC_WB_IDX(wb_idx), .DESC_WB_DW0(wb_dw0), .BUF_REQ(buf_req),
    .BUF_ADDR(buf_addr), .BUF_LEN(buf_len), .IN_DATA(in_data),
    .IN_VALID(in_valid), .IN_READY(in_ready), .TX_DATA(tx_data),
    .TX_LAST(tx_last), .TX_VALID(tx_valid), .TX_READY(tx_ready),
    .LARGE_SEND(large_send), .VLAN_ID(vlan_id), .VLAN_RANK(vlan_rank),
    .VLAN_CFI(vlan_cfi));
  host_ring_model host_ring_model_i (
    .clk(core_clk), .rst_n(rst_n), .desc_req(desc_req),
    .desc_idx(desc_idx), .desc_valid(desc_valid), .dw0(dw0), .dw1(dw1),
    .dw2(dw2), .dw3(dw3), .wb_valid(wb_valid), .wb_idx(wb_idx),
    .wb_dw0(wb_dw0), .buf_req(buf_req), .buf_addr(buf_addr),
    .buf_len(buf_len), .in_data(in_data), .in_valid(in_valid),
    .in_ready(in_ready), .stall(in_stall));
  // ---------------------------------------------
  // Helpers
  // ---------------------------------------------
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task chk(input logic [79:0] got, input logic [79:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task give_verdict();
    $display("Checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Hand a descriptor over and build the expected byte stream
  task arm(input int idx, input logic [31:0] d0, input logic [15:0] tag,
           input logic ins);
    logic [63:0] a;
    logic ls;
    int n;
    a = {xs(), xs()};
    ls = d0[LAST_BIT];
    n = d0[15:0];
    armed[idx] = d0;
    host_ring_model_i.ring[idx][1] = {14'h0000, ins, 1'b0, tag};
    host_ring_model_i.ring[idx][2] = a[31:0];
    host_ring_model_i.ring[idx][3] = a[63:32];
    host_ring_model_i.ring[idx][0] = d0;
    buf_q.push_back({a, d0[15:0]});
    if (d0[FIRST_BIT])
    begin
      pkt_cnt = 0;
      cur_tag = tag;
      cur_ins = ins;
      cur_lg = d0[BIG_SEND_BIT];
      cur_mss = d0[MSS_MSB:MSS_LSB];
      pkt_q.push_back({cur_lg, tag});
    end
    for (int k = 0; k < n; k++)
    begin
      pkt_cnt++;
      exp_q.push_back({(ls && k == n - 1) || (cur_lg && cur_mss != 0 &&
        pkt_cnt % cur_mss == 0), a[7:0] + k[7:0]});
      if (cur_ins && pkt_cnt == 12 && !(ls && k == n - 1))
      begin
        exp_q.push_back({1'b0, TPID[15:8]});
        exp_q.push_back({1'b0, TPID[7:0]});
        exp_q.push_back({1'b0, cur_tag[7:0]});
        exp_q.push_back({1'b0, cur_tag[15:8]});
      end
    end
  endtask
  task kick(input int hold_cyc);
    @(negedge core_clk) tx_kick = 1'b1;
    @(negedge core_clk) tx_kick = 1'b0;
    hold = hold_cyc > 0;
    repeat (hold_cyc + 3) @(negedge core_clk);
    if (hold_cyc > 0)
      chk({tx_valid, in_ready}, 2'b10);
    hold = 1'b0;
    for (int i = 0; i < 3000 && engine_busy !== 1'b0; i++)
      @(negedge core_clk);
    chk(engine_busy, 1'b0);
  endtask
  // ---------------------------------------------
  // Clock, random drive, monitors, watchdog
  // ---------------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  always @(negedge core_clk)
  begin
    r = xs();
    tx_ready <= !hold && (r[0] || r[1]);
    in_stall <= r[2] && r[3];
  end
  always @(posedge core_clk)
    if (!ignore)
    begin
      if (tx_valid && tx_ready)
        chk({tx_last, tx_data}, exp_q.size() > 0 ? exp_q.pop_front() : 'x);
      if (buf_req)
        chk({buf_addr, buf_len}, buf_q.pop_front());
      if (pkt_sent)
      begin
        p = pkt_q.pop_front();
        chk({large_send, vlan_id, vlan_rank, vlan_cfi},
          {p[16], p[3:0], p[15:8], p[7:5], p[4]});
      end
    end
  initial
  begin
    #1_000_000;
    bad_count++;
    give_verdict();
  end
  // ---------------------------------------------
  // Main sequence
  // ---------------------------------------------
  initial
  begin
    seed = 32'h8fef_0828;
    {rst_n, tx_kick, err_clear, in_stall, hold, ignore} = '0;
    {tx_enable, tx_ready} = 2'b11;
    bad_count = 0;
    tests_run = 0;
    pkt_cnt = 0;
    cur_mss = 0;
    for (int i = 0; i < RING_DEPTH; i++)
      for (int j = 0; j < 4; j++)
        host_ring_model_i.ring[i][j] = 32'h0000_0000;
    repeat (16) @(posedge core_clk);
    @(negedge core_clk) rst_n = 1'b1;
    arm(0, {4'hb, 1'b0, 11'h000, 16'd20}, 16'h5ab3, 1'b1);
    arm(1, {4'ha, 1'b0, 11'h000, 16'd8}, 16'h1234, 1'b1);
    arm(2, {4'h9, 1'b0, 11'h000, 16'd6}, 16'h1234, 1'b1);
    arm(3, {4'hf, 1'b1, 11'h005, 16'd13}, 16'h0e71, 1'b0);
    kick(0);
    chk(desc_idx, 0);
    chk({exp_q.size(), pkt_q.size()}, 0);
    for (int i = 0; i < 4; i++)
      chk(host_ring_model_i.ring[i][0], armed[i] & ~OWN_MASK);
    tx_enable = 1'b0;
    arm(0, {4'hb, 1'b0, 11'h000, 16'd40}, 16'h0000, 1'b0);
    kick(0);
    chk(host_ring_model_i.ring[0][0], armed[0]);
    tx_enable = 1'b1;
    kick(60);
    chk({desc_idx, exp_q.size()}, {10'h001, 32'h0000_0000});
    ignore = 1'b1;
    host_ring_model_i.ring[1][0] = {4'h9, 1'b0, 11'h000, 16'd4};
    kick(0);
    chk(err_sequence, 1'b1);
    @(negedge core_clk) err_clear = 1'b1;
    @(negedge core_clk) err_clear = 1'b0;
    chk({err_sequence, err_oversize}, 2'b00);
    give_verdict();
  end
endmodule
`default_nettype wire
